// file: rtl/cce_pkg.sv
// Constants for the call, clear-file and watchdog-clear execution block
package cce_pkg;
    // ************************************************************
    // Register map (AHB-Lite byte addresses)
    // ************************************************************
    localparam logic [7:0] CCE_CTRL_OFS = 8'h00;
    localparam logic [7:0] CCE_INSTR_OFS = 8'h04;
    localparam logic [7:0] CCE_LIT2_OFS = 8'h08;
    localparam logic [7:0] CCE_PC_OFS = 8'h0C;
    localparam logic [7:0] CCE_WREG_OFS = 8'h10;
    localparam logic [7:0] CCE_BANK_OFS = 8'h14;
    localparam logic [7:0] CCE_FLAGS_OFS = 8'h18;
    localparam logic [7:0] CCE_STACK_OFS = 8'h1C;
    localparam logic [7:0] CCE_SHADOW_OFS = 8'h20;
    localparam logic [7:0] CCE_WATCHDOG_OFS = 8'h24;
    localparam logic [7:0] CCE_FILE_OFS = 8'h28;
    localparam logic [7:0] CCE_FADDR_OFS = 8'h2C;
    // ************************************************************
    // Opcode fields
    // ************************************************************
    localparam logic [6:0] CCE_CALL_HI = 7'h76;
    localparam logic [3:0] CCE_CALL2_HI = 4'hF;
    localparam logic [6:0] CCE_ZF_HI = 7'h35;
    localparam logic [15:0] CCE_KICK_OP = 16'h0004;
    localparam int CCE_ZERO_BIT = 2;
    localparam int CCE_EXPIRY_BIT = 4;
    localparam int CCE_SLEEP_BIT = 3;
    localparam logic [20:0] CCE_RET_STEP = 21'h000004;
    localparam logic [1:0] CCE_NOP_LAST = 2'h3;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CCE_FLAGS_RST = 8'h18;
    localparam logic [7:0] CCE_WATCHDOG_RST = 8'h00;
    localparam logic [7:0] CCE_POST_RST = 8'h00;
    typedef enum logic [4:0] {
        CCE_Q1 = 5'h01,
        CCE_Q2 = 5'h02,
        CCE_Q3 = 5'h04,
        CCE_Q4 = 5'h08,
        CCE_CALL2 = 5'h10
    } cce_phase_e;
endpackage

// file: rtl/cce_exec.sv
// Execution of subroutine call, clear-file and watchdog-clear instructions
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Call: two words, two cycles, k to PC
// - Call pushes call address plus four
// - Fast call copies W, bank, flags to shadows
// - Clear-file writes zero, sets zero flag only
// - Clear-file decode 0110101a, access bit selects bank
// - Pattern 0x0004 is watchdog-clear, one cycle
// - Watchdog-clear zeroes watchdog counter
// - Watchdog-clear zeroes watchdog postscaler
// - Watchdog-clear sets expiry and sleep flags
module cce_exec
    import cce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Execution status
    output logic busy,
    output logic [20:0] pc_out,
    output logic [7:0] watchdog_count
);
    // ************************************************************
    // State
    // ************************************************************
    cce_phase_e ph_q, ph_d;
    logic [15:0] instr_q, instr_d;
    logic [15:0] lit2_q, lit2_d;
    logic [20:0] pc_q, pc_d;
    logic [7:0] wreg_q, wreg_d;
    logic [7:0] bank_select_q, bank_select_d;
    logic [7:0] flags_q, flags_d;
    logic [20:0] stack_top_entry_q, stack_top_entry_d;
    logic [7:0] accumulator_shadow_q, accumulator_shadow_d;
    logic [7:0] bank_select_shadow_q, bank_select_shadow_d;
    logic [7:0] flags_shadow_q, flags_shadow_d;
    logic [7:0] watchdog_q, watchdog_d;
    logic [7:0] wd_post_q, wd_post_d;
    logic [7:0] file_q, file_d;
    logic [11:0] faddr_q, faddr_d;
    logic [7:0] fdata_q, fdata_d;
    logic busy_q, busy_d;
    logic hreadyout_q, hreadyout_d;
    logic [1:0] nop_cnt_q, nop_cnt_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic wr_pend_q, wr_pend_d;
    logic rd_pend_q, rd_pend_d;
    logic [7:0] addr_q, addr_d;
    logic go;
    logic is_call, is_zf, is_kick;
    logic [31:0] rd_mux;

    // ************************************************************
    // Decode
    // ************************************************************
    always_comb begin
        is_call = (instr_q[15:9] == CCE_CALL_HI);
        is_zf = (instr_q[15:9] == CCE_ZF_HI);
        is_kick = (instr_q == CCE_KICK_OP);
    end

    always_comb begin
        case (addr_q)
            CCE_CTRL_OFS: rd_mux = {31'h0, busy_q};
            CCE_INSTR_OFS: rd_mux = {16'h0, instr_q};
            CCE_LIT2_OFS: rd_mux = {16'h0, lit2_q};
            CCE_PC_OFS: rd_mux = {11'h0, pc_q};
            CCE_WREG_OFS: rd_mux = {24'h0, wreg_q};
            CCE_BANK_OFS: rd_mux = {24'h0, bank_select_q};
            CCE_FLAGS_OFS: rd_mux = {24'h0, flags_q};
            CCE_STACK_OFS: rd_mux = {11'h0, stack_top_entry_q};
            CCE_SHADOW_OFS: rd_mux = {8'h0, flags_shadow_q, bank_select_shadow_q,
                accumulator_shadow_q};
            CCE_WATCHDOG_OFS: rd_mux = {16'h0, wd_post_q, watchdog_q};
            CCE_FILE_OFS: rd_mux = {24'h0, file_q};
            CCE_FADDR_OFS: rd_mux = {20'h0, faddr_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // ************************************************************
    // Bus slave and execution sequencing
    // ************************************************************
    always_comb begin
        ph_d = ph_q;
        instr_d = instr_q;
        lit2_d = lit2_q;
        pc_d = pc_q;
        wreg_d = wreg_q;
        bank_select_d = bank_select_q;
        flags_d = flags_q;
        stack_top_entry_d = stack_top_entry_q;
        accumulator_shadow_d = accumulator_shadow_q;
        bank_select_shadow_d = bank_select_shadow_q;
        flags_shadow_d = flags_shadow_q;
        watchdog_d = watchdog_q;
        wd_post_d = wd_post_q;
        file_d = file_q;
        faddr_d = faddr_q;
        fdata_d = fdata_q;
        busy_d = busy_q;
        nop_cnt_d = nop_cnt_q;
        hrdata_d = hrdata_q;
        go = 1'b0;
        wr_pend_d = 1'b0;
        rd_pend_d = 1'b0;
        addr_d = addr_q;
        if (hsel && hready && htrans[1]) begin
            addr_d = haddr[7:0];
            wr_pend_d = hwrite;
            rd_pend_d = !hwrite;
        end
        hreadyout_d = !rd_pend_d;
        if (rd_pend_q) begin
            hrdata_d = rd_mux;
        end
        if (wr_pend_q && !busy_q) begin
            case (addr_q)
                CCE_CTRL_OFS: go = hwdata[0];
                CCE_INSTR_OFS: instr_d = hwdata[15:0];
                CCE_LIT2_OFS: lit2_d = hwdata[15:0];
                CCE_PC_OFS: pc_d = hwdata[20:0];
                CCE_WREG_OFS: wreg_d = hwdata[7:0];
                CCE_BANK_OFS: bank_select_d = hwdata[7:0];
                CCE_FLAGS_OFS: flags_d = hwdata[7:0];
                CCE_WATCHDOG_OFS: begin
                    watchdog_d = hwdata[7:0];
                    wd_post_d = hwdata[15:8];
                end
                CCE_FILE_OFS: file_d = hwdata[7:0];
                default: ;
            endcase
        end
        case (ph_q)
            CCE_Q1: begin
                if (go) begin
                    busy_d = 1'b1;
                    ph_d = CCE_Q2;
                end
            end
            CCE_Q2: begin
                // Read operand, form bank address
                faddr_d = instr_q[8] ? {bank_select_q[3:0], instr_q[7:0]} :
                    {4'h0, instr_q[7:0]};
                fdata_d = file_q;
                ph_d = CCE_Q3;
            end
            CCE_Q3: begin
                if (is_call) begin
                    stack_top_entry_d = 21'(pc_q + CCE_RET_STEP);
                    if (instr_q[8]) begin
                        accumulator_shadow_d = wreg_q;
                        bank_select_shadow_d = bank_select_q;
                        flags_shadow_d = flags_q;
                    end
                end
                if (is_zf) begin
                    fdata_d = 8'h00;
                end
                ph_d = CCE_Q4;
            end
            CCE_Q4: begin
                if (is_zf) begin
                    file_d = fdata_q;
                    flags_d[CCE_ZERO_BIT] = 1'b1;
                end
                if (is_kick) begin
                    watchdog_d = CCE_WATCHDOG_RST;
                    wd_post_d = CCE_POST_RST;
                    flags_d[CCE_EXPIRY_BIT] = 1'b1;
                    flags_d[CCE_SLEEP_BIT] = 1'b1;
                end
                if (is_call && lit2_q[15:12] == CCE_CALL2_HI) begin
                    pc_d = {lit2_q[11:0], instr_q[7:0], 1'b0};
                    nop_cnt_d = 2'h0;
                    ph_d = CCE_CALL2;
                end else begin
                    if (!is_call) begin
                        pc_d = 21'(pc_q + 21'h000002);
                    end
                    busy_d = 1'b0;
                    ph_d = CCE_Q1;
                end
            end
            CCE_CALL2: begin
                // Second instruction cycle: four no-op phases
                if (nop_cnt_q == CCE_NOP_LAST) begin
                    busy_d = 1'b0;
                    ph_d = CCE_Q1;
                end else begin
                    nop_cnt_d = 2'(nop_cnt_q + 2'h1);
                end
            end
            default: ph_d = CCE_Q1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ph_q <= CCE_Q1;
            instr_q <= 16'h0000;
            lit2_q <= 16'h0000;
            pc_q <= 21'h000000;
            wreg_q <= 8'h00;
            bank_select_q <= 8'h00;
            flags_q <= CCE_FLAGS_RST;
            stack_top_entry_q <= 21'h000000;
            accumulator_shadow_q <= 8'h00;
            bank_select_shadow_q <= 8'h00;
            flags_shadow_q <= 8'h00;
            watchdog_q <= CCE_WATCHDOG_RST;
            wd_post_q <= CCE_POST_RST;
            file_q <= 8'h00;
            faddr_q <= 12'h000;
            fdata_q <= 8'h00;
            busy_q <= 1'b0;
            hreadyout_q <= 1'b1;
            nop_cnt_q <= 2'h0;
            hrdata_q <= 32'h0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            ph_q <= ph_d;
            instr_q <= instr_d;
            lit2_q <= lit2_d;
            pc_q <= pc_d;
            wreg_q <= wreg_d;
            bank_select_q <= bank_select_d;
            flags_q <= flags_d;
            stack_top_entry_q <= stack_top_entry_d;
            accumulator_shadow_q <= accumulator_shadow_d;
            bank_select_shadow_q <= bank_select_shadow_d;
            flags_shadow_q <= flags_shadow_d;
            watchdog_q <= watchdog_d;
            wd_post_q <= wd_post_d;
            file_q <= file_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
            busy_q <= busy_d;
            hreadyout_q <= hreadyout_d;
            nop_cnt_q <= nop_cnt_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q <= addr_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        hrdata = hrdata_q;
        hreadyout = hreadyout_q;
        hresp = 1'b0;
        busy = busy_q;
        pc_out = pc_q;
        watchdog_count = watchdog_q;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_call_pc_load: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q4 && is_call && lit2_q[15:12] == CCE_CALL2_HI) |=>
        (pc_q == {$past(lit2_q[11:0]), $past(instr_q[7:0]), 1'b0} && busy_q)
        ##1 busy_q [*3] ##1 !busy_q)
        else $error("call target not loaded");
    a_call_push: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q3 && is_call) |=> stack_top_entry_q == $past(pc_q) + CCE_RET_STEP)
        else $error("return address wrong");
    a_fast_shadow: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q3 && is_call && instr_q[8]) |=>
        accumulator_shadow_q == $past(wreg_q) && flags_shadow_q == $past(flags_q)
        && bank_select_shadow_q == $past(bank_select_q))
        else $error("shadow copy missing");
    a_zero_file: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q4 && is_zf) |=> file_q == 8'h00 && flags_q[CCE_ZERO_BIT]
        && flags_q[1:0] == $past(flags_q[1:0]))
        else $error("clear-file result wrong");
    a_bank_sel: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q2 && is_zf && !instr_q[8]) |=> faddr_q[11:8] == 4'h0)
        else $error("access bank not selected");
    a_zf_timing: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q1 && go && is_zf) |=> ##3 (ph_q == CCE_Q1 && !busy_q))
        else $error("clear-file not one cycle");
    a_kick_time: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q1 && go && is_kick) |=> busy_q [*3] ##1 !busy_q)
        else $error("watchdog-clear not one cycle");
    a_kick_count: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q4 && is_kick) |=> watchdog_q == CCE_WATCHDOG_RST)
        else $error("watchdog not cleared");
    a_kick_post: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q4 && is_kick) |=> wd_post_q == CCE_POST_RST)
        else $error("postscaler not cleared");
    a_kick_flags: assert property (@(posedge clk) disable iff (reset)
        (ph_q == CCE_Q4 && is_kick) |=> flags_q[CCE_EXPIRY_BIT] && flags_q[CCE_SLEEP_BIT])
        else $error("status flags not set");
endmodule

// file: verification/call_clear_instr_exec_bench.sv
// Self-checking bench for the call, clear-file and watchdog-clear block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module call_clear_instr_exec_bench;
    import cce_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic hsel = 0;
    logic hwrite = 0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, busy;
    logic [20:0] pc_out;
    logic [7:0] watchdog_count;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v, sh, seed_v;
    logic rd_ph = 0;
    logic [7:0] w, b, f, fa;
    logic [20:0] pc;
    logic [19:0] k;

    cce_exec u_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
        .pc_out(pc_out), .watchdog_count(watchdog_count));

    initial begin
        forever #20 clk = ~clk;
    end

    // ************************************************************
    // Read data monitor against queued expectations
    // ************************************************************
    always @(posedge clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK(hrdata, exp_v)
            `CHK(hresp, 1'b0)
        end
        if (hsel && hreadyout === 1'b1 && htrans[1])
            rd_ph <= !hwrite;
        else if (hreadyout === 1'b1)
            rd_ph <= 1'b0;
    end

    // ************************************************************
    // Bus and execution tasks
    // ************************************************************
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic run(input logic [15:0] op, input logic [15:0] lit, input int ncyc);
        int n;
        n = 0;
        bus(CCE_INSTR_OFS, 1'b1, {16'h0, op});
        bus(CCE_LIT2_OFS, 1'b1, {16'h0, lit});
        bus(CCE_CTRL_OFS, 1'b1, 32'h1);
        #1;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk) #1;
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge clk) #1;
            n++;
        end
        `CHK(n, ncyc)
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        seed_v = $urandom(32'h045F31D3);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(CCE_FLAGS_OFS, {24'h0, CCE_FLAGS_RST});
        rd(CCE_WATCHDOG_OFS, 32'h0);
        rd(8'h40, 32'h0);
        `CHK(pc_out, 21'h0)
        $display("Test reset values done");
        for (int s = 1; s >= 0; s--) begin
            w = 8'($urandom);
            b = 8'($urandom) & 8'h0F;
            f = 8'($urandom) & 8'h1F;
            pc = 21'($urandom) & 21'h1FFFFE;
            k = 20'($urandom);
            bus(CCE_WREG_OFS, 1'b1, {24'h0, w});
            bus(CCE_BANK_OFS, 1'b1, {24'h0, b});
            bus(CCE_FLAGS_OFS, 1'b1, {24'h0, f});
            bus(CCE_PC_OFS, 1'b1, {11'h0, pc});
            run({CCE_CALL_HI, s[0], k[7:0]}, {CCE_CALL2_HI, k[19:8]}, 7);
            `CHK(pc_out, {k, 1'b0})
            rd(CCE_STACK_OFS, {11'h0, pc + CCE_RET_STEP});
            if (s == 1)
                sh = {8'h0, f, b, w};
            rd(CCE_SHADOW_OFS, sh);
            $display("Test call with save option %0d done", s);
        end
        for (int a = 0; a < 2; a++) begin
            b = 8'($urandom) & 8'h0F;
            f = 8'($urandom) & 8'h1B;
            fa = 8'($urandom);
            bus(CCE_BANK_OFS, 1'b1, {24'h0, b});
            bus(CCE_FLAGS_OFS, 1'b1, {24'h0, f});
            bus(CCE_FILE_OFS, 1'b1, {24'h0, fa | 8'h01});
            pc = pc_out;
            run({CCE_ZF_HI, a[0], fa}, 16'h0, 3);
            `CHK(pc_out, pc + 21'h2)
            rd(CCE_FILE_OFS, 32'h0);
            rd(CCE_FLAGS_OFS, {24'h0, f | 8'h04});
            rd(CCE_FADDR_OFS, (a == 1) ? {20'h0, b[3:0], fa} : {24'h0, fa});
            $display("Test clear-file with access bit %0d done", a);
        end
        f = 8'($urandom) & 8'h07;
        bus(CCE_WATCHDOG_OFS, 1'b1, {16'h0, 16'h0101 | 16'($urandom)});
        bus(CCE_FLAGS_OFS, 1'b1, {24'h0, f});
        pc = pc_out;
        run(CCE_KICK_OP, 16'h0, 3);
        `CHK(pc_out, pc + 21'h2)
        `CHK(watchdog_count, 8'h00)
        rd(CCE_WATCHDOG_OFS, 32'h0);
        rd(CCE_FLAGS_OFS, {24'h0, f | 8'h18});
        $display("Test watchdog clear done");
        repeat (4) @(posedge clk);
        end_of_test();
    end

    initial begin
        #2000000;
        failures++;
        $display("CHECK FAILED %0t run did not finish in time", $time);
        end_of_test();
    end
endmodule
